// ---- include/tsw_pkg.sv ----
// Constants, types and event carrier for the two-wire slave of the sensor
package tsw_pkg;

	// Address byte layout: four fixed upper bits, three variant bits, R/W
	localparam logic [3:0] ADDR_BASE = 4'he;
	localparam logic [7:0] BCAST_WR_ADDR = 8'h00;
	localparam logic [7:0] BCAST_RD_ADDR = 8'h01;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [2:0] VARIANT_RESET = 3'h0;

	// Bit counting within a byte
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_DONE = 4'h8;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] SLOT_ZERO = 4'h0;
	localparam logic [3:0] SLOT_ONE = 4'h1;

	// SCL-low timeout, 30 ms at 40 MHz
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int TIMEOUT_MS = 30;
	localparam int TIMEOUT_CYC = (SYS_CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int TO_W = 21;
	localparam logic [TO_W-1:0] TO_ZERO = 21'h0;
	localparam logic [TO_W-1:0] TO_ONE = 21'h1;

	typedef enum logic [1:0]
	{
		EV_INDEX = 2'b00,
		EV_DATA = 2'b01,
		EV_RESET = 2'b10
	} tsw_ev_kind_t;

	typedef struct packed
	{
		tsw_ev_kind_t kind;
		logic [7:0] data;
	} tsw_event_t;

	localparam tsw_event_t EVENT_RESET = '{kind: EV_INDEX, data: 8'h00};

	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK = 3'b010,
		S_IDX = 3'b011,
		S_DATA = 3'b100,
		S_TX = 3'b101,
		S_MACK = 3'b110,
		S_IGNORE = 3'b111
	} tsw_state_t;

endpackage : tsw_pkg

// ---- rtl/tsw_slave.sv ----
// Two-wire slave front end of the temperature sensor, two clock domains
//
// Operation
// - Byte after a write address is the index; it loads the index pointer.
// - Reads return the register picked by the last index; index persists.
// - Device never drives clock; pulls data low only for acks and bits.
// - Write: ack address, ack index, store and ack each data byte.
// - Read: ack address, shift out indexed byte; master ends with nack.
// - Ack general call; second byte reset command restores power-up values.
// - Other general-call second bytes such as address acquire are acked and load the index pointer.
// - High-speed master code is not acked but switches filters to fast.
// - High-speed mode lasts until a stop, then default filtering returns.
// - Clock low for timeout resets interface, releases data, awaits start.
// - Ack broadcast read and broadcast write addresses and execute them.
// - Broadcast write: ack index and data, store data at the index.
// - Broadcast read: each variant sends in its own slot, lowest first.
// - Master acks every slot; after a nack later slots stay silent.
// - Any number of data bytes accepted between start and stop.
// - All bytes shifted most significant bit first.
// - Written value takes effect only after the whole data byte arrives.
// - Address byte is seven address bits plus direction; one per variant.
`timescale 1ns/1ps
module tsw_slave
	import tsw_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic bus_clk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [2:0] variant_i,
	input wire logic [7:0] rd_data,
	output logic [7:0] reg_index,
	output logic wr_en,
	output logic [7:0] wr_data,
	output logic gc_reset,
	output logic hs_mode
);

	import tsw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bus-clock domain: pin sampling and crossings in

	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic to_s1, to_s2, to_s3, ack_s1, ack_s2, ack_s3;
	logic [2:0] var_s1, var_s2;
	logic to_tog_q, rd_ack_tog_q;
	logic [7:0] rd_hold_q;

	always_ff @(posedge bus_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{to_s1, to_s2, to_s3} <= 3'h0;
			{ack_s1, ack_s2, ack_s3} <= 3'h0;
			var_s1 <= VARIANT_RESET;
			var_s2 <= VARIANT_RESET;
		end
		else
		begin
			{scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
			{to_s1, to_s2, to_s3} <= {to_tog_q, to_s1, to_s2};
			{ack_s1, ack_s2, ack_s3} <= {rd_ack_tog_q, ack_s1, ack_s2};
			var_s1 <= variant_i;
			var_s2 <= var_s1;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, to_evt, rd_ack_evt;
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign to_evt = to_s2 ^ to_s3;
	assign rd_ack_evt = ack_s2 ^ ack_s3;

	////////////////////////////////////////////////////////////////////////
	// Bus-clock domain: slave state machine

	tsw_state_t st_q, st_d, nxt_q, nxt_d;
	logic [3:0] cnt_q, cnt_d, slot_q, slot_d;
	logic [7:0] sh_q, sh_d, rd_byte_q, rd_byte_d;
	logic [2:0] var_q, var_d;
	logic ph_q, ph_d, mine_q, mine_d;
	logic read_q, read_d, bcast_q, bcast_d, ack_q, ack_d;
	logic sda_oe_q, sda_oe_d, hs_q, hs_d;
	logic ev_tog_q, ev_tog_d, rd_req_tog_q, rd_req_tog_d;
	tsw_event_t ev_q, ev_d;

	// Tx load shared by the address ack and each acked slot
	function automatic logic slot_owner(input logic bc, input logic [3:0] s,
		input logic [2:0] v);
		slot_owner = !bc || (s == {1'b0, v});
	endfunction : slot_owner

	always_comb
	begin
		logic [7:0] b;
		logic own;
		b = {sh_q[6:0], sda_s2};
		own = 1'b0;
		st_d = st_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		slot_d = slot_q;
		sh_d = sh_q;
		rd_byte_d = rd_ack_evt ? rd_hold_q : rd_byte_q;
		// Strap is static; a one-shot catch would grab the reset value
		var_d = var_s2;
		ph_d = ph_q;
		mine_d = mine_q;
		read_d = read_q;
		bcast_d = bcast_q;
		ack_d = ack_q;
		sda_oe_d = sda_oe_q;
		hs_d = hs_q;
		ev_tog_d = ev_tog_q;
		ev_d = ev_q;
		rd_req_tog_d = rd_req_tog_q;
		if (to_evt)
		begin
			st_d = S_IDLE;
			sda_oe_d = 1'b0;
			ph_d = 1'b0;
		end
		else if (bus_start)
		begin
			st_d = S_ADDR;
			cnt_d = BIT_ZERO;
			sda_oe_d = 1'b0;
			ph_d = 1'b0;
		end
		else if (bus_stop)
		begin
			st_d = S_IDLE;
			sda_oe_d = 1'b0;
			hs_d = 1'b0;
			ph_d = 1'b0;
		end
		else
		begin
			unique case (st_q)
				S_IDLE, S_IGNORE:
				begin
					sda_oe_d = 1'b0;
				end
				S_ADDR, S_IDX, S_DATA:
				begin
					if (scl_rise)
					begin
						sh_d = b;
						cnt_d = cnt_q + BIT_ONE;
						if (cnt_q == BIT_LAST)
						begin
							cnt_d = BIT_ZERO;
							ack_d = 1'b1;
							st_d = S_ACK;
							if (st_q == S_ADDR)
							begin
								own = (b[7:1] == {ADDR_BASE, var_q});
								if (b[7:3] == HS_CODE_TOP)
								begin
									st_d = S_IGNORE;
									hs_d = 1'b1;
								end
								else if (own || b == BCAST_WR_ADDR ||
									b == BCAST_RD_ADDR)
								begin
									read_d = b[0];
									bcast_d = !own;
									slot_d = SLOT_ZERO;
									nxt_d = b[0] ? S_TX : S_IDX;
									rd_req_tog_d = b[0] ? ~rd_req_tog_q :
										rd_req_tog_q;
								end
								else
								begin
									st_d = S_IGNORE;
								end
							end
							else if (st_q == S_IDX && bcast_q &&
								b == GC_RESET_CMD)
							begin
								ev_d = '{kind: EV_RESET, data: b};
								ev_tog_d = ~ev_tog_q;
								nxt_d = S_IGNORE;
							end
							else
							begin
								// Index and data both cross as events
								ev_d = '{kind: (st_q == S_IDX) ? EV_INDEX :
									EV_DATA, data: b};
								ev_tog_d = ~ev_tog_q;
								nxt_d = S_DATA;
							end
						end
					end
				end
				S_ACK:
				begin
					if (scl_fall)
					begin
						if (!ph_q)
						begin
							sda_oe_d = ack_q;
							ph_d = 1'b1;
						end
						else
						begin
							ph_d = 1'b0;
							st_d = nxt_q;
							sda_oe_d = 1'b0;
							if (nxt_q == S_TX)
							begin
								mine_d = slot_owner(bcast_q, slot_q, var_q);
								sh_d = {rd_byte_q[6:0], 1'b0};
								sda_oe_d = mine_d & ~rd_byte_q[7];
								cnt_d = BIT_ONE;
							end
						end
					end
				end
				S_TX:
				begin
					if (scl_fall)
					begin
						if (cnt_q == BIT_DONE)
						begin
							sda_oe_d = 1'b0;
							st_d = S_MACK;
							cnt_d = BIT_ZERO;
						end
						else
						begin
							sda_oe_d = mine_q & ~sh_q[7];
							sh_d = {sh_q[6:0], 1'b0};
							cnt_d = cnt_q + BIT_ONE;
						end
					end
				end
				S_MACK:
				begin
					if (scl_rise)
					begin
						if (sda_s2)
						begin
							st_d = S_IGNORE;
						end
						else
						begin
							ph_d = 1'b1;
						end
					end
					else if (scl_fall && ph_q)
					begin
						ph_d = 1'b0;
						slot_d = slot_q + SLOT_ONE;
						mine_d = slot_owner(bcast_q, slot_d, var_q);
						sh_d = {rd_byte_q[6:0], 1'b0};
						sda_oe_d = mine_d & ~rd_byte_q[7];
						cnt_d = BIT_ONE;
						st_d = S_TX;
					end
				end
			endcase
		end
	end

	always_ff @(posedge bus_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= S_IDLE;
			nxt_q <= S_IDLE;
			cnt_q <= BIT_ZERO;
			slot_q <= SLOT_ZERO;
			sh_q <= INDEX_RESET;
			rd_byte_q <= INDEX_RESET;
			var_q <= VARIANT_RESET;
			ph_q <= 1'b0;
			mine_q <= 1'b0;
			read_q <= 1'b0;
			bcast_q <= 1'b0;
			ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			hs_q <= 1'b0;
			ev_tog_q <= 1'b0;
			ev_q <= EVENT_RESET;
			rd_req_tog_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			slot_q <= slot_d;
			sh_q <= sh_d;
			rd_byte_q <= rd_byte_d;
			var_q <= var_d;
			ph_q <= ph_d;
			mine_q <= mine_d;
			read_q <= read_d;
			bcast_q <= bcast_d;
			ack_q <= ack_d;
			sda_oe_q <= sda_oe_d;
			hs_q <= hs_d;
			ev_tog_q <= ev_tog_d;
			ev_q <= ev_d;
			rd_req_tog_q <= rd_req_tog_d;
		end
	end

	// Device only ever pulls low; clock line is never driven
	assign sda_o = 1'b0 & sda_oe_q;
	assign scl_o = 1'b0 & sda_oe_q;
	assign scl_oe = 1'b0 & sda_oe_q;
	assign sda_oe = sda_oe_q;
	assign hs_mode = hs_q;

	////////////////////////////////////////////////////////////////////////
	// System-clock domain: register side and timeout timer

	logic sc_s1, sc_s2, ev_s1, ev_s2, ev_s3, rq_s1, rq_s2, rq_s3;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{sc_s1, sc_s2} <= 2'h3;
			{ev_s1, ev_s2, ev_s3} <= 3'h0;
			{rq_s1, rq_s2, rq_s3} <= 3'h0;
		end
		else
		begin
			{sc_s1, sc_s2} <= {scl_i, sc_s1};
			{ev_s1, ev_s2, ev_s3} <= {ev_tog_q, ev_s1, ev_s2};
			{rq_s1, rq_s2, rq_s3} <= {rd_req_tog_q, rq_s1, rq_s2};
		end
	end

	logic [7:0] ptr_q, ptr_d, wr_data_q, wr_data_d, rd_hold_d;
	logic wr_en_q, wr_en_d, gc_q, gc_d, to_tog_d, rd_ack_tog_d;
	logic fired_q, fired_d;
	logic [TO_W-1:0] to_cnt_q, to_cnt_d;

	always_comb
	begin
		ptr_d = ptr_q;
		wr_data_d = wr_data_q;
		wr_en_d = 1'b0;
		gc_d = 1'b0;
		rd_hold_d = rd_hold_q;
		rd_ack_tog_d = rd_ack_tog_q;
		to_cnt_d = to_cnt_q;
		fired_d = fired_q;
		to_tog_d = to_tog_q;
		// Payload is stable for a whole byte time after the toggle
		if (ev_s2 ^ ev_s3)
		begin
			unique case (ev_q.kind)
				EV_INDEX: ptr_d = ev_q.data;
				EV_DATA:
				begin
					wr_en_d = 1'b1;
					wr_data_d = ev_q.data;
				end
				EV_RESET:
				begin
					ptr_d = INDEX_RESET;
					gc_d = 1'b1;
				end
				default: ptr_d = ptr_q;
			endcase
		end
		if (rq_s2 ^ rq_s3)
		begin
			rd_hold_d = rd_data;
			rd_ack_tog_d = ~rd_ack_tog_q;
		end
		if (sc_s2)
		begin
			to_cnt_d = TO_ZERO;
			fired_d = 1'b0;
		end
		else if (!fired_q)
		begin
			to_cnt_d = to_cnt_q + TO_ONE;
			if (to_cnt_q == TO_W'(TIMEOUT_CYCLES - 1))
			begin
				fired_d = 1'b1;
				to_tog_d = ~to_tog_q;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ptr_q <= INDEX_RESET;
			wr_data_q <= INDEX_RESET;
			wr_en_q <= 1'b0;
			gc_q <= 1'b0;
			rd_hold_q <= INDEX_RESET;
			rd_ack_tog_q <= 1'b0;
			to_cnt_q <= TO_ZERO;
			fired_q <= 1'b0;
			to_tog_q <= 1'b0;
		end
		else
		begin
			ptr_q <= ptr_d;
			wr_data_q <= wr_data_d;
			wr_en_q <= wr_en_d;
			gc_q <= gc_d;
			rd_hold_q <= rd_hold_d;
			rd_ack_tog_q <= rd_ack_tog_d;
			to_cnt_q <= to_cnt_d;
			fired_q <= fired_d;
			to_tog_q <= to_tog_d;
		end
	end

	assign reg_index = ptr_q;
	assign wr_en = wr_en_q;
	assign wr_data = wr_data_q;
	assign gc_reset = gc_q;

endmodule : tsw_slave

// ---- bench/tsw_slave_checker.sv ----
// Assertion checker bound to the two-wire slave ports
`timescale 1ns/1ps
module tsw_slave_checker
#(
	parameter int unsigned TIMEOUT_CYCLES = 200
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic bus_clk,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [2:0] variant_i,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] reg_index,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic gc_reset,
	input wire logic hs_mode
);
	import tsw_pkg::*;
	////////////////////////////////////////////////////////////////
	// Counts how long the clock line has stayed low
	logic [31:0] low_q;
	logic [31:0] low_d;
	always_comb
	begin
		low_d = scl_i ? 32'h0 : low_q + 32'h1;
	end
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			low_q <= 32'h0;
		else
			low_q <= low_d;
	end
	// Clock falls since high speed began; the code's ack slot ends at two
	logic scl_prev_q, hs_prev_q;
	logic [1:0] hs_falls_q, hs_falls_d;
	always_comb
	begin
		hs_falls_d = hs_falls_q;
		if (hs_mode && !hs_prev_q)
			hs_falls_d = 2'h0;
		else if (scl_prev_q && !scl_i && hs_falls_q != 2'h2)
			hs_falls_d = hs_falls_q + 2'h1;
	end
	always_ff @(posedge bus_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_prev_q <= 1'b1;
			hs_prev_q <= 1'b0;
			hs_falls_q <= 2'h2;
		end
		else
		begin
			scl_prev_q <= scl_i;
			hs_prev_q <= hs_mode;
			hs_falls_q <= hs_falls_d;
		end
	end
	scl_never_driven_a: assert property (
		@(posedge bus_clk) disable iff (!resetn) !scl_oe && !scl_o)
		else $error("slave drove the clock line");
	sda_open_drain_a: assert property (
		@(posedge bus_clk) disable iff (!resetn) sda_oe |-> !sda_o)
		else $error("data line driven high");
	sda_moves_low_a: assert property (
		@(posedge bus_clk) disable iff (!resetn) $changed(sda_oe) |-> !scl_i)
		else $error("data line moved while clock high");
	write_pulse_a: assert property (
		@(posedge sys_clk) disable iff (!resetn) wr_en |=> !wr_en [*8])
		else $error("write strobe too long");
	wr_data_hold_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		$changed(wr_data) |-> wr_en || $past(wr_en))
		else $error("write data changed without write");
	gc_clears_index_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		gc_reset |-> !wr_en ##[0:1] reg_index == INDEX_RESET)
		else $error("index kept after general reset");
	timeout_release_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		low_q > TIMEOUT_CYCLES + 32'd16 |-> !sda_oe)
		else $error("data line held after timeout");
	hs_stop_clear_a: assert property (
		@(posedge bus_clk) disable iff (!resetn) $fell(hs_mode) |-> scl_i)
		else $error("high speed left without stop");
	hs_no_ack_a: assert property (
		@(posedge bus_clk) disable iff (!resetn)
		hs_mode && hs_falls_q != 2'h2 |-> !sda_oe)
		else $error("high speed code acknowledged");
endmodule : tsw_slave_checker

// ---- bench/tsw_master_model.sv ----
// Behavioural bus master that clocks the slave
`timescale 1ns/1ps
module tsw_master_model
#(
	parameter int Q = 200
)
(
	output logic scl_m,
	output logic sda_m,
	input wire logic sda_line
);
	////////////////////////////////////////////////////////////////
	// Released lines read as high through the pull-ups
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Bit period 4*Q keeps well above the minimum rate
	task automatic bit_io(input logic b, output logic r);
		#Q sda_m = b;
		#Q scl_m = 1'b1;
		#Q r = sda_line;
		#Q scl_m = 1'b0;
	endtask : bit_io
	task automatic start;
		#Q sda_m = 1'b1;
		#Q scl_m = 1'b1;
		#Q sda_m = 1'b0;
		#Q scl_m = 1'b0;
	endtask : start
	task automatic stop;
		#Q sda_m = 1'b0;
		#Q scl_m = 1'b1;
		#Q sda_m = 1'b1;
		#Q;
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : send
	task automatic recv(input logic mack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(!mack, r);
	endtask : recv
endmodule : tsw_master_model

// ---- bench/tsw_slave_test.sv ----
// Self-checking bench for the two-wire slave
`timescale 1ns/1ps
module tsw_slave_test;
	import tsw_pkg::*;
	localparam int unsigned TO_CYC = 200;
	localparam logic [2:0] VAR = 3'h2;
	localparam logic [7:0] OWN_W = {ADDR_BASE, VAR, 1'b0};
	localparam logic [7:0] OWN_R = {ADDR_BASE, VAR, 1'b1};
	logic sys_clk = 1'b0;
	logic bus_clk = 1'b0;
	logic resetn = 1'b0;
	logic scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe;
	logic wr_en, gc_reset, hs_mode;
	logic [7:0] rd_data, reg_index, wr_data;
	logic [7:0] mem [0:255];
	int err_total = 0;
	int n_compared = 0;
	wire logic scl_line = scl_m & !scl_oe;
	wire logic sda_line = sda_m & !sda_oe;
	////////////////////////////////////////////////////////////////
	always #12.5 sys_clk = ~sys_clk;
	initial
	begin
		#1.7;
		forever #3 bus_clk = ~bus_clk;
	end
	// Stand-in register file behind the index pointer
	initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
	always @(posedge sys_clk)
	begin
		if (gc_reset)
			foreach (mem[i]) mem[i] <= 8'(i) ^ 8'h3c;
		else if (wr_en)
			mem[reg_index] <= wr_data;
	end
	assign rd_data = mem[reg_index];
	tsw_master_model m (.scl_m(scl_m), .sda_m(sda_m), .sda_line(sda_line));
	tsw_slave #(.TIMEOUT_CYCLES(TO_CYC)) dut (.sys_clk(sys_clk),
		.resetn(resetn), .bus_clk(bus_clk), .scl_i(scl_line),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe(sda_oe), .variant_i(VAR), .rd_data(rd_data),
		.reg_index(reg_index), .wr_en(wr_en), .wr_data(wr_data),
		.gc_reset(gc_reset), .hs_mode(hs_mode));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic sx(input logic [7:0] b, input logic e);
		logic a;
		m.send(b, a);
		chk({7'h0, a}, {7'h0, e});
	endtask : sx
	task automatic rx(input logic mack, input logic [7:0] exp);
		logic [7:0] d;
		m.recv(mack, d);
		chk(d, exp);
	endtask : rx
	task automatic t_write_read;
		m.start();
		sx(OWN_W, 1'b1);
		sx(8'h02, 1'b1);
		chk(reg_index, 8'h02);
		sx(8'h5a, 1'b1);
		chk(mem[2], 8'h5a);
		sx(8'hc3, 1'b1);
		chk(mem[2], 8'hc3);
		m.start();
		sx(OWN_R, 1'b1);
		rx(1'b1, 8'hc3);
		rx(1'b0, 8'hc3);
		m.stop();
		m.start();
		sx(OWN_W, 1'b1);
		sx(8'h05, 1'b1);
		m.start();
		sx(OWN_R, 1'b1);
		rx(1'b0, 8'h39);
		m.stop();
		$display("write and read done");
	endtask : t_write_read
	task automatic t_wrong;
		m.start();
		sx({ADDR_BASE, VAR + 3'h1, 1'b0}, 1'b0);
		m.stop();
		$display("foreign address done");
	endtask : t_wrong
	task automatic t_bcast;
		m.start();
		sx(BCAST_WR_ADDR, 1'b1);
		sx(8'h03, 1'b1);
		sx(8'h77, 1'b1);
		chk(mem[3], 8'h77);
		m.start();
		sx(BCAST_RD_ADDR, 1'b1);
		for (int k = 0; k < 4; k++)
			rx(1'b1, (k == VAR) ? 8'h77 : 8'hff);
		m.start();
		sx(BCAST_RD_ADDR, 1'b1);
		rx(1'b0, 8'hff);
		rx(1'b1, 8'hff);
		rx(1'b1, 8'hff);
		m.stop();
		$display("broadcast done");
	endtask : t_bcast
	task automatic t_timeout;
		m.start();
		sx(OWN_R, 1'b1);
		repeat (TO_CYC + 40) @(posedge sys_clk);
		chk({7'h0, sda_line}, 8'h01);
		m.stop();
		m.start();
		sx(OWN_R, 1'b1);
		rx(1'b0, 8'h77);
		m.stop();
		$display("timeout done");
	endtask : t_timeout
	task automatic t_hs;
		m.start();
		sx(8'h0d, 1'b0);
		chk({7'h0, hs_mode}, 8'h01);
		m.start();
		sx(OWN_W, 1'b1);
		chk({7'h0, hs_mode}, 8'h01);
		m.stop();
		chk({7'h0, hs_mode}, 8'h00);
		$display("high speed done");
	endtask : t_hs
	task automatic t_gc;
		m.start();
		sx(8'h00, 1'b1);
		sx(8'h04, 1'b1);
		m.stop();
		chk(mem[3], 8'h77);
		m.start();
		sx(8'h00, 1'b1);
		sx(GC_RESET_CMD, 1'b1);
		m.stop();
		chk(reg_index, INDEX_RESET);
		chk(mem[3], 8'h3f);
		$display("general call done");
	endtask : t_gc
	task automatic conclude;
		$display("%0d compared, %0d mismatched", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial
	begin
		#2_000_000;
		err_total++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		conclude();
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		#2 resetn = 1'b1;
		repeat (4) @(posedge sys_clk);
		#2;
		chk(reg_index, INDEX_RESET);
		t_write_read();
		t_wrong();
		t_bcast();
		t_timeout();
		t_hs();
		t_gc();
		conclude();
	end
endmodule : tsw_slave_test
bind tsw_slave tsw_slave_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (
	.sys_clk(sys_clk), .resetn(resetn), .bus_clk(bus_clk), .scl_i(scl_i),
	.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .variant_i(variant_i), .rd_data(rd_data),
	.reg_index(reg_index), .wr_en(wr_en), .wr_data(wr_data),
	.gc_reset(gc_reset), .hs_mode(hs_mode));
